// ==== verilog/asc_scan_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R01: A set scan select bit includes its input; a clear bit skips it.
// R02: Scan select bit 31 and bits 26 to 20 do nothing and read as zero.
// R03: Outside-window mode sets a hit bit on a buffer write or a match.
// R04: Other compare modes set a channel's hit bit only on a valid match.
// R05: Compare hit bits 31 to 20 do nothing and read as zero.
// R06: Scan select bits of absent inputs drop by pin count (28, 36/40, 48).
// R07: Compare hit bits are dropped per pin count in the same pattern.
// R08: Compare mode 11 is outside, 10 inside, 01 greater, 00 less than.
// R09: The scan sequencer runs only while auto-scan enable is set.
// R10: Selected inputs convert in ascending order, then wrap to the lowest.
module asc_scan_ctrl #(
    parameter int PIN_COUNT = 64
) (
    input  wire logic                          core_clk,
    input  wire logic                          srst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [asc_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [asc_pkg::DATA_W-1:0]    pwdata,
    output logic                               pready,
    output logic      [asc_pkg::DATA_W-1:0]    prdata,
    output logic                               pslverr,
    output logic                               convStart,
    output logic      [asc_pkg::CHAN_W-1:0]    convChannel,
    input  wire logic                          convDone,
    input  asc_pkg::asc_result_s               convResult,
    output logic                               irq
);
    import asc_pkg::*;

    localparam logic [31:0] SCAN_IMPL = SCAN_FULL & ~missMask(PIN_COUNT);
    localparam logic [31:0] HIT_IMPL  = HIT_FULL & ~missMask(PIN_COUNT);

    logic [31:0]       scanQ, scan_d;
    logic [31:0]       hitQ, hit_d;
    asc_ctrl_s         ctrlQ, ctrl_d;
    logic [IRQ_W-1:0]  statQ, stat_d;
    logic [IRQ_W-1:0]  maskQ, mask_d;
    asc_seq_e          seqQ, seq_d;
    logic [CHAN_W-1:0] chanQ, chan_d;
    logic              startQ, start_d;
    logic              preadyQ;
    logic [31:0]       prdataQ, prdata_d;
    logic              pslverrQ;
    logic              irqQ;
    logic [31:0]       rdMux;
    logic              addrOk;
    logic [CHAN_W-1:0] pickNext;
    logic              pickWrapped;
    logic              pickAny;
    logic              match;

    // APB handshake: one wait state, pready from a flop
    wire accessPhase = psel & penable;
    wire answerNow   = accessPhase & ~preadyQ;
    wire xferDone    = accessPhase & preadyQ;
    wire wrEn        = xferDone & pwrite & ~pslverrQ;
    wire rdEn        = xferDone & ~pwrite;
    wire wrScan      = wrEn & (paddr == OFF_SCAN);
    wire wrHit       = wrEn & (paddr == OFF_HIT);
    wire wrCtrl      = wrEn & (paddr == OFF_CTRL);
    wire wrMask      = wrEn & (paddr == OFF_MASK);
    wire rdStat      = rdEn & (paddr == OFF_STAT);

    always_comb begin
        addrOk = 1'b1;
        rdMux  = ZERO_WORD;
        if (paddr == OFF_SCAN) begin
            rdMux = scanQ & SCAN_IMPL; // see R02
        end else if (paddr == OFF_HIT) begin
            rdMux = hitQ & HIT_IMPL; // see R05
        end else if (paddr == OFF_CTRL) begin
            rdMux[CTRL_ASE_BIT]               = ctrlQ.ase;
            rdMux[CTRL_CM_LSB+1:CTRL_CM_LSB]  = ctrlQ.mode;
        end else if (paddr == OFF_STAT) begin
            rdMux[IRQ_W-1:0] = statQ;
        end else if (paddr == OFF_MASK) begin
            rdMux[IRQ_W-1:0] = maskQ;
        end else if (paddr == OFF_SEQ) begin
            rdMux[CHAN_W-1:0]   = chanQ;
            rdMux[SEQ_BUSY_BIT] = (seqQ == SEQ_WAIT);
        end else begin
            addrOk = 1'b0;
        end
    end

    assign prdata_d = answerNow ? rdMux : ZERO_WORD;

    // sequencer
    asc_scan_pick u_pick (
        .sel     (scanQ[NUM_IN-1:0]),
        .cur     (chanQ),
        .nxt     (pickNext),
        .wrapped (pickWrapped),
        .any     (pickAny)
    );

    asc_compare u_cmp (
        .mode  (ctrlQ.mode), // see R08
        .res   (convResult),
        .match (match)
    );

    always_comb begin
        seq_d   = seqQ;
        chan_d  = chanQ;
        start_d = 1'b0;
        case (seqQ)
            SEQ_IDLE: begin
                if (!ctrlQ.ase) begin
                    chan_d = IDLE_CHAN; // see R09
                end else if (pickAny) begin
                    chan_d  = pickNext; // see R01, R10
                    start_d = 1'b1;
                    seq_d   = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (!ctrlQ.ase) begin
                    chan_d = IDLE_CHAN; // see R09
                    seq_d  = SEQ_IDLE;
                end else if (convDone) begin
                    seq_d = SEQ_IDLE;
                end
            end
            default: seq_d = SEQ_IDLE;
        endcase
    end

    wire        doneEvt   = (seqQ == SEQ_WAIT) & ctrlQ.ase & convDone;
    wire        hitChan   = chanQ < HIT_CHANS;
    wire        hitCause  = (ctrlQ.mode == CM_OUT) | match; // see R03, R04
    wire [31:0] oneHot    = 32'h0000_0001 << chanQ;
    wire        hitFire   = doneEvt & hitChan & hitCause;
    wire [31:0] hitSet    = hitFire ? oneHot & HIT_IMPL : ZERO_WORD; // see R07
    wire [1:0]  wrMode    = pwdata[CTRL_CM_LSB+1:CTRL_CM_LSB];
    wire [IRQ_W-1:0] evt  = {|hitSet, doneEvt & match, doneEvt & pickWrapped};

    // software writes to the hit register, but a new hit wins
    assign hit_d  = (wrHit ? (pwdata & HIT_IMPL) : hitQ) | hitSet;
    assign scan_d = wrScan ? (pwdata & SCAN_IMPL) : scanQ; // see R06
    assign ctrl_d = wrCtrl ? '{ase:  pwdata[CTRL_ASE_BIT],
                               mode: asc_cm_e'(wrMode)}
                           : ctrlQ;
    assign mask_d = wrMask ? pwdata[IRQ_W-1:0] : maskQ;
    // read clears only the bits that were reported
    assign stat_d = (statQ & ~(rdStat ? prdataQ[IRQ_W-1:0] : '0)) | evt;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            scanQ <= ZERO_WORD;
            hitQ  <= ZERO_WORD;
            ctrlQ <= '{ase: 1'b0, mode: CM_LT};
            statQ <= '0;
            maskQ <= '0;
        end else begin
            scanQ <= scan_d;
            hitQ  <= hit_d;
            ctrlQ <= ctrl_d;
            statQ <= stat_d;
            maskQ <= mask_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            seqQ   <= SEQ_IDLE;
            chanQ  <= IDLE_CHAN;
            startQ <= 1'b0;
        end else begin
            seqQ   <= seq_d;
            chanQ  <= chan_d;
            startQ <= start_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            preadyQ  <= 1'b0;
            prdataQ  <= ZERO_WORD;
            pslverrQ <= 1'b0;
            irqQ     <= 1'b0;
        end else begin
            preadyQ  <= answerNow;
            prdataQ  <= prdata_d;
            pslverrQ <= answerNow & ~addrOk;
            irqQ     <= |(stat_d & mask_d);
        end
    end

    assign pready      = preadyQ;
    assign prdata      = prdataQ;
    assign pslverr     = pslverrQ;
    assign convStart   = startQ;
    assign convChannel = chanQ;
    assign irq         = irqQ;

    // checks
    property p_scan_reserved;
        @(posedge core_clk) disable iff (srst)
        rdEn && paddr == OFF_SCAN |-> (prdataQ & ~SCAN_IMPL) == ZERO_WORD;
    endproperty
    a_scan_reserved: assert property (p_scan_reserved) // see R02
        else $error("reserved scan select bit read as one");

    property p_hit_reserved;
        @(posedge core_clk) disable iff (srst)
        rdEn && paddr == OFF_HIT |-> (prdataQ & ~HIT_IMPL) == ZERO_WORD;
    endproperty
    a_hit_reserved: assert property (p_hit_reserved) // see R05
        else $error("reserved compare hit bit read as one");

    property p_absent_hit;
        @(posedge core_clk) disable iff (srst)
        (hitQ & ~HIT_IMPL) == ZERO_WORD && (scanQ & ~SCAN_IMPL) == ZERO_WORD;
    endproperty
    a_absent_hit: assert property (p_absent_hit) // see R06, R07
        else $error("bit of an absent input is set");

    property p_start_selected;
        @(posedge core_clk) disable iff (srst)
        startQ && !$past(wrScan) |-> scanQ[chanQ];
    endproperty
    a_start_selected: assert property (p_start_selected) // see R01
        else $error("conversion started on an unselected input");

    property p_hit_outside;
        @(posedge core_clk) disable iff (srst)
        doneEvt && ctrlQ.mode == CM_OUT && hitChan && HIT_IMPL[chanQ]
        |=> hitQ[$past(chanQ)];
    endproperty
    a_hit_outside: assert property (p_hit_outside) // see R03
        else $error("written buffer did not set its hit bit");

    property p_hit_nomatch;
        @(posedge core_clk) disable iff (srst)
        doneEvt && ctrlQ.mode != CM_OUT && !match && !wrHit
        |=> hitQ == $past(hitQ);
    endproperty
    a_hit_nomatch: assert property (p_hit_nomatch) // see R04
        else $error("hit bit changed without a match");

    property p_mode_less;
        @(posedge core_clk) disable iff (srst)
        doneEvt && ctrlQ.mode == CM_LT
        |-> match == (convResult.data < convResult.low);
    endproperty
    a_mode_less: assert property (p_mode_less) // see R08
        else $error("less-than compare gave the wrong answer");

    property p_no_scan_disabled;
        @(posedge core_clk) disable iff (srst)
        !ctrlQ.ase |=> !startQ ##1 !startQ || ctrlQ.ase;
    endproperty
    a_no_scan_disabled: assert property (p_no_scan_disabled) // see R09
        else $error("conversion started with auto-scan disabled");

    property p_ascending;
        @(posedge core_clk) disable iff (srst)
        doneEvt && !pickWrapped && !wrEn
        |-> ##2 startQ && chanQ > $past(chanQ, 2);
    endproperty
    a_ascending: assert property (p_ascending) // see R10
        else $error("scan did not move to a higher input");

    property p_hit_match;
        @(posedge core_clk) disable iff (srst)
        doneEvt && match && hitChan && HIT_IMPL[chanQ]
        |=> hitQ[$past(chanQ)];
    endproperty
    a_hit_match: assert property (p_hit_match) // see R04
        else $error("valid match did not set its hit bit");

    property p_hit_sticky;
        @(posedge core_clk) disable iff (srst)
        !wrHit |=> (hitQ & $past(hitQ)) == $past(hitQ);
    endproperty
    a_hit_sticky: assert property (p_hit_sticky) // see R03
        else $error("hit bit cleared without a software write");

    property p_mode_inside;
        @(posedge core_clk) disable iff (srst)
        doneEvt && ctrlQ.mode == CM_IN
        |-> match == (convResult.data >= convResult.low
                      && convResult.data <= convResult.high);
    endproperty
    a_mode_inside: assert property (p_mode_inside) // see R08
        else $error("inside-window compare gave the wrong answer");

    property p_mode_outside;
        @(posedge core_clk) disable iff (srst)
        doneEvt && ctrlQ.mode == CM_OUT
        |-> match == (convResult.data < convResult.low
                      || convResult.data > convResult.high);
    endproperty
    a_mode_outside: assert property (p_mode_outside) // see R08
        else $error("outside-window compare gave the wrong answer");

    property p_idle_disabled;
        @(posedge core_clk) disable iff (srst)
        !ctrlQ.ase |=> convChannel == IDLE_CHAN;
    endproperty
    a_idle_disabled: assert property (p_idle_disabled) // see R09
        else $error("channel not parked while auto-scan is off");

    c_wrap: cover property (@(posedge core_clk) disable iff (srst)
        doneEvt && pickWrapped);
    c_match_hit: cover property (@(posedge core_clk) disable iff (srst)
        doneEvt && match && hitChan);
    c_irq: cover property (@(posedge core_clk) disable iff (srst)
        $rose(irqQ));
    c_stat_clear: cover property (@(posedge core_clk) disable iff (srst)
        rdStat && prdataQ[IRQ_W-1:0] != '0);
    c_out_written: cover property (@(posedge core_clk) disable iff (srst)
        doneEvt && ctrlQ.mode == CM_OUT && !match);

endmodule // asc_scan_ctrl

// ==== verilog/asc_pkg.sv ====
package asc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_SCAN = 8'h00;
    localparam logic [7:0] OFF_HIT  = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_SEQ  = 8'h14;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CHAN_W = 5;
    localparam int unsigned NUM_IN = 31;
    localparam int unsigned RES_W  = 12;

    // implemented bits before package trimming
    localparam logic [31:0] SCAN_FULL = 32'h780F_FFFF;
    localparam logic [31:0] HIT_FULL  = 32'h000F_FFFF;
    localparam logic [31:0] MISS_28   = 32'h000F_F000;
    localparam logic [31:0] MISS_36   = 32'h000F_8000;
    localparam logic [31:0] MISS_48   = 32'h0003_C000;
    localparam logic [31:0] MISS_NONE = 32'h0000_0000;
    localparam logic [4:0]  HIT_CHANS = 5'h14;

    // control register fields
    localparam int unsigned CTRL_ASE_BIT = 15;
    localparam int unsigned CTRL_CM_LSB  = 0;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

    // sequencer readback fields
    localparam int unsigned SEQ_BUSY_BIT = 8;

    // interrupt status / mask bits
    localparam int unsigned IRQ_SCAN  = 0;
    localparam int unsigned IRQ_MATCH = 1;
    localparam int unsigned IRQ_HIT   = 2;
    localparam int unsigned IRQ_W     = 3;

    localparam logic [4:0]  IDLE_CHAN  = 5'h1F;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

    typedef enum logic [1:0] {
        CM_LT  = 2'b00,
        CM_GT  = 2'b01,
        CM_IN  = 2'b10,
        CM_OUT = 2'b11
    } asc_cm_e;

    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_WAIT = 1'b1
    } asc_seq_e;

    typedef struct packed {
        logic             ase;
        asc_cm_e          mode;
    } asc_ctrl_s;

    typedef struct packed {
        logic [RES_W-1:0] data;
        logic [RES_W-1:0] low;
        logic [RES_W-1:0] high;
    } asc_result_s;

    // bits that do not exist for a given pin count
    function automatic logic [31:0] missMask(input int pins);
        logic [31:0] m;
        m = MISS_NONE;
        if (pins == 28) begin
            m = MISS_28;
        end else if (pins == 36 || pins == 40) begin
            m = MISS_36;
        end else if (pins == 48) begin
            m = MISS_48;
        end
        return m;
    endfunction

endpackage

// ==== verilog/asc_scan_pick.sv ====
`timescale 1ns/1ps
module asc_scan_pick (
    input  wire logic [asc_pkg::NUM_IN-1:0] sel,
    input  wire logic [asc_pkg::CHAN_W-1:0] cur,
    output logic      [asc_pkg::CHAN_W-1:0] nxt,
    output logic                            wrapped,
    output logic                            any
);
    import asc_pkg::*;

    logic [CHAN_W-1:0] above;
    logic [CHAN_W-1:0] lowest;
    logic              aboveFound;

    // lowest selected input above cur, else lowest overall
    always_comb begin
        above      = '0;
        lowest     = '0;
        aboveFound = 1'b0;
        for (int i = NUM_IN - 1; i >= 0; i--) begin
            if (sel[i]) begin
                lowest = CHAN_W'(i);
            end
            if (sel[i] && (CHAN_W'(i) > cur)) begin
                above      = CHAN_W'(i);
                aboveFound = 1'b1;
            end
        end
    end

    assign nxt     = aboveFound ? above : lowest;
    assign wrapped = ~aboveFound;
    assign any     = |sel;

endmodule // asc_scan_pick

// ==== verilog/asc_compare.sv ====
`timescale 1ns/1ps
module asc_compare (
    input  asc_pkg::asc_cm_e     mode,
    input  asc_pkg::asc_result_s res,
    output logic                 match
);
    import asc_pkg::*;

    wire belowLow  = res.data < res.low;
    wire aboveLow  = res.data > res.low;
    wire aboveHigh = res.data > res.high;

    always_comb begin
        case (mode)
            CM_LT:   match = belowLow;
            CM_GT:   match = aboveLow;
            CM_IN:   match = ~belowLow & ~aboveHigh;
            default: match = belowLow | aboveHigh;
        endcase
    end

endmodule // asc_compare

// ==== bench/adc_scan_compare_hit_tb.sv ====
`timescale 1ns/1ps
module adc_scan_compare_hit_tb;
    import asc_pkg::*;

    logic                      core_clk = 1'b0;
    logic                      srst;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic        [ADDR_W-1:0]  paddr;
    logic        [DATA_W-1:0]  pwdata;
    logic                      pready;
    logic        [DATA_W-1:0]  prdata;
    logic                      pslverr;
    logic                      convStart;
    logic        [CHAN_W-1:0]  convChannel;
    logic                      convDone;
    asc_result_s               convResult;
    logic                      irq;
    int                        error_cnt = 0;
    int                        cmp_count = 0;

    localparam logic [11:0] T050 = 12'h032;
    localparam logic [11:0] T100 = 12'h064;
    localparam logic [11:0] T150 = 12'h096;
    localparam logic [11:0] T200 = 12'h0C8;

    asc_scan_ctrl #(.PIN_COUNT(48)) dut (
        .core_clk    (core_clk),
        .srst        (srst),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pready      (pready),
        .prdata      (prdata),
        .pslverr     (pslverr),
        .convStart   (convStart),
        .convChannel (convChannel),
        .convDone    (convDone),
        .convResult  (convResult),
        .irq         (irq)
    );

    always #5 core_clk = ~core_clk;

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic hang(input string what);
        error_cnt++;
        $display("mismatch at %0t: %s timed out", $time, what);
        summarize();
    endtask

    // entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) hang("bus access");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, ZERO_WORD, r, e);
    endtask

    task automatic convert(input logic [4:0] ch, input logic [11:0] dat,
                           input logic [11:0] lo, input logic [11:0] hi);
        int          n;
        logic [31:0] r;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (convStart === 1'b1) break;
        end
        if (n == 50) hang("conversion start");
        check(32'(convChannel), 32'(ch), "scan channel");
        rd(OFF_SEQ, r);
        check(r, 32'(ch) | (32'h1 << SEQ_BUSY_BIT), "seq busy");
        convDone <= 1'b1;
        convResult <= '{data: dat, low: lo, high: hi};
        @(posedge core_clk);
        convDone <= 1'b0;
    endtask

    // one conversion on input 4, then hit flag, irq and status checks
    task automatic run_mode(input asc_cm_e m, input logic [11:0] lo,
                            input logic [11:0] hi, input logic [11:0] dat,
                            input logic msk, input logic h, input logic i);
        logic [31:0] r;
        wr(OFF_CTRL, ZERO_WORD);
        wr(OFF_HIT, ZERO_WORD);
        rd(OFF_STAT, r);
        wr(OFF_MASK, 32'(msk) << IRQ_HIT);
        wr(OFF_SCAN, 32'h0000_0010);
        wr(OFF_CTRL, 32'h0000_8000 | 32'(m));
        convert(5'h04, dat, lo, hi);
        wr(OFF_CTRL, ZERO_WORD);
        rd(OFF_HIT, r);
        check(r, 32'(h) << 4, "hit flags");
        check(32'(irq), 32'(i), "irq level");
        rd(OFF_STAT, r);
        check((r >> IRQ_HIT) & 32'h0000_0001, 32'(h), "hit event");
        check(32'(r[IRQ_SCAN]), 32'h0000_0001, "wrap event");
        if (m != CM_OUT) begin
            check(32'(r[IRQ_MATCH]), 32'(h), "match event");
        end
        repeat (2) @(posedge core_clk);
        check(32'(irq), ZERO_WORD, "irq after status read");
        $display("compare mode %0d test done", m);
    endtask

    initial begin
        logic [31:0] r;
        logic        e;
        logic [7:0]  regs[5];
        logic [4:0]  order[4];
        int          n;
        regs = '{OFF_SCAN, OFF_HIT, OFF_CTRL, OFF_STAT, OFF_MASK};
        order = '{5'h02, 5'h05, 5'h1C, 5'h02};
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = ZERO_WORD;
        convDone = 1'b0;
        convResult = '0;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (n = 0; n < 5; n++) begin
            rd(regs[n], r);
            check(r, ZERO_WORD, "reset value");
        end
        check(32'(convChannel), 32'(IDLE_CHAN), "idle channel");
        rd(OFF_SEQ, r);
        check(r, 32'(IDLE_CHAN), "idle sequencer");
        $display("reset test done");
        wr(OFF_SCAN, 32'hFFFF_FFFF);
        rd(OFF_SCAN, r);
        check(r, SCAN_FULL & ~MISS_48, "scan select bits");
        wr(OFF_HIT, 32'hFFFF_FFFF);
        rd(OFF_HIT, r);
        check(r, HIT_FULL & ~MISS_48, "hit flag bits");
        apb(1'b0, 8'h40, ZERO_WORD, r, e);
        check(r, ZERO_WORD, "unmapped read data");
        check(32'(e), 32'h0000_0001, "unmapped error");
        $display("register map test done");
        n = 0;
        repeat (30) begin
            @(posedge core_clk);
            if (convStart === 1'b1) n++;
        end
        check(32'(n), ZERO_WORD, "start while disabled");
        wr(OFF_SCAN, 32'h1000_0024);
        wr(OFF_CTRL, 32'h0000_8000);
        for (n = 0; n < 4; n++) begin
            convert(order[n], 12'h000, 12'h000, 12'hFFF);
        end
        wr(OFF_CTRL, ZERO_WORD);
        repeat (2) @(posedge core_clk);
        check(32'(convChannel), 32'(IDLE_CHAN), "disabled channel");
        rd(OFF_SEQ, r);
        check(r, 32'(IDLE_CHAN), "disabled sequencer");
        $display("scan order test done");
        run_mode(CM_LT, T100, T100, T050, 1'b1, 1'b1, 1'b1);
        run_mode(CM_LT, T100, T100, T150, 1'b1, 1'b0, 1'b0);
        run_mode(CM_GT, T100, T100, T150, 1'b1, 1'b1, 1'b1);
        run_mode(CM_IN, T100, T200, T150, 1'b1, 1'b1, 1'b1);
        run_mode(CM_IN, T100, T200, T050, 1'b1, 1'b0, 1'b0);
        run_mode(CM_OUT, T100, T200, T150, 1'b1, 1'b1, 1'b1);
        run_mode(CM_OUT, T100, T200, T050, 1'b0, 1'b1, 1'b0);
        summarize();
    end

endmodule // adc_scan_compare_hit_tb
